/* hw/rcr_consts.svh */
`ifndef RCR_CONSTS_SVH
`define RCR_CONSTS_SVH

// register byte offsets inside the block
`define RCR_OFF_FLAGS 12'h004
`define RCR_OFF_MASK 12'h010
`define RCR_OFF_LAST 12'h014
`define RCR_OFF_COUNT 12'h018

// flag bit positions
`define RCR_BIT_POR 0
`define RCR_BIT_PIN 1
`define RCR_BIT_WDT 2
`define RCR_BIT_LVR 3
`define RCR_BIT_BOD 4
`define RCR_BIT_SYS 5
`define RCR_BIT_CPU 7

// implemented flag bits, bit 6 reserved
`define RCR_FLAGS_USED 8'hBF
// flag value left by a power-on reset
`define RCR_FLAGS_POR 8'h01
`define RCR_FLAGS_ZERO 8'h00
`define RCR_MASK_RST 8'h00
`define RCR_COUNT_ONE 8'h01
`define RCR_COUNT_MAX 8'hFF
`define RCR_WORD_ZERO 32'h0000_0000
`define RCR_NSRC 7

`endif

/* hw/rcr_pkg.sv */
package rcr_pkg;

  // one byte of per-source flags
  typedef logic [7:0] rcr_flags_t;

  // most recent recorded cause, read back as a small code
  typedef enum logic [2:0] {
    rcr_cause_none,
    rcr_cause_por,
    rcr_cause_pin,
    rcr_cause_wdt,
    rcr_cause_lvr,
    rcr_cause_bod,
    rcr_cause_sys,
    rcr_cause_cpu
  } rcr_cause_t;

endpackage : rcr_pkg

/* hw/rcr_sync.sv */
`timescale 1ns/10ps
// two-flop synchroniser for a bus of independent levels
module rcr_sync #(
  parameter int W = 7
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta;

  // first stage feeds only the second stage
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end

endmodule : rcr_sync

/* hw/rcr_rise.sv */
`timescale 1ns/10ps
// rising-edge detector on already synchronised levels
module rcr_rise #(
  parameter int W = 7
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] rise
);

  logic [W-1:0] prev;

  // remember last level
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prev <= '0;
    end else begin
      prev <= d;
    end
  end

  assign rise = d & ~prev;

endmodule : rcr_rise

/* hw/rcr_top.sv */
`timescale 1ns/10ps
`include "rcr_consts.svh"
module rcr_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic por_rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic core_only_rst_req,
  input wire logic core_sys_rst_req,
  input wire logic brownout_rst_req,
  input wire logic low_voltage_rst_req,
  input wire logic watchdog_rst_req,
  input wire logic pin_rst_req,
  input wire logic chip_rst_req,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq
);

  // source index inside the request bus
  localparam int SRC_POR = 0;
  localparam int SRC_PIN = 1;
  localparam int SRC_WDT = 2;
  localparam int SRC_LVR = 3;
  localparam int SRC_BOD = 4;
  localparam int SRC_SYS = 5;
  localparam int SRC_CPU = 6;

  logic [`RCR_NSRC-1:0] req_raw;
  logic [`RCR_NSRC-1:0] req_sync;
  logic [`RCR_NSRC-1:0] req_rise;

  rcr_pkg::rcr_flags_t reset_cause_flags;
  rcr_pkg::rcr_flags_t next_reset_cause_flags;
  rcr_pkg::rcr_flags_t flag_set;
  rcr_pkg::rcr_flags_t flag_clr;
  rcr_pkg::rcr_flags_t irq_mask;
  rcr_pkg::rcr_cause_t last_cause;
  rcr_pkg::rcr_cause_t next_last_cause;
  logic [7:0] event_count;
  logic [7:0] next_event_count;

  logic setup_phase;
  logic wr_access;
  logic rd_setup;
  logic [31:0] next_prdata;
  logic next_err;

  // true when the address hits the given register
  function automatic logic hit(
    input logic [11:0] addr,
    input logic [11:0] off
  );
    hit = (addr == off);
  endfunction : hit

  // true when the address hits any implemented register
  function automatic logic mapped(input logic [11:0] addr);
    mapped = hit(addr, `RCR_OFF_FLAGS) || hit(addr, `RCR_OFF_MASK) ||
             hit(addr, `RCR_OFF_LAST) || hit(addr, `RCR_OFF_COUNT);
  endfunction : mapped

  // pick the highest-ranked cause among simultaneous flag sets
  function automatic rcr_pkg::rcr_cause_t encode(
    input rcr_pkg::rcr_flags_t s
  );
    if (s[`RCR_BIT_POR]) begin
      encode = rcr_pkg::rcr_cause_por;
    end else if (s[`RCR_BIT_PIN]) begin
      encode = rcr_pkg::rcr_cause_pin;
    end else if (s[`RCR_BIT_WDT]) begin
      encode = rcr_pkg::rcr_cause_wdt;
    end else if (s[`RCR_BIT_LVR]) begin
      encode = rcr_pkg::rcr_cause_lvr;
    end else if (s[`RCR_BIT_BOD]) begin
      encode = rcr_pkg::rcr_cause_bod;
    end else if (s[`RCR_BIT_SYS]) begin
      encode = rcr_pkg::rcr_cause_sys;
    end else if (s[`RCR_BIT_CPU]) begin
      encode = rcr_pkg::rcr_cause_cpu;
    end else begin
      encode = rcr_pkg::rcr_cause_none;
    end
  endfunction : encode

  // gather the reset requests; the chip reset shares the power-on flag
  assign req_raw[SRC_POR] = chip_rst_req;
  assign req_raw[SRC_PIN] = pin_rst_req;
  assign req_raw[SRC_WDT] = watchdog_rst_req;
  assign req_raw[SRC_LVR] = low_voltage_rst_req;
  assign req_raw[SRC_BOD] = brownout_rst_req;
  assign req_raw[SRC_SYS] = core_sys_rst_req;
  assign req_raw[SRC_CPU] = core_only_rst_req;

  // requests come from other reset logic: resync on the surviving reset
  rcr_sync #(
    .W(`RCR_NSRC)
  ) u_sync (
    .clk(pclk),
    .rstn(por_rstn),
    .d(req_raw),
    .q(req_sync)
  );

  // one pulse per request, so a long request sets its flag once
  rcr_rise #(
    .W(`RCR_NSRC)
  ) u_rise (
    .clk(pclk),
    .rstn(por_rstn),
    .d(req_sync),
    .rise(req_rise)
  );

  // map each request pulse onto its flag bit
  always_comb begin
    flag_set = `RCR_FLAGS_ZERO;
    flag_set[`RCR_BIT_CPU] = req_rise[SRC_CPU];
    flag_set[`RCR_BIT_SYS] = req_rise[SRC_SYS];
    flag_set[`RCR_BIT_BOD] = req_rise[SRC_BOD];
    flag_set[`RCR_BIT_LVR] = req_rise[SRC_LVR];
    flag_set[`RCR_BIT_WDT] = req_rise[SRC_WDT];
    flag_set[`RCR_BIT_PIN] = req_rise[SRC_PIN];
    flag_set[`RCR_BIT_POR] = req_rise[SRC_POR];
  end

  // apb phase decode
  assign setup_phase = psel && !penable;
  assign rd_setup = setup_phase && !pwrite;
  assign wr_access = psel && penable && pready && pwrite &&
                     !pslverr;

  // write-one-to-clear from byte lane 0 of the flags word
  always_comb begin
    flag_clr = `RCR_FLAGS_ZERO;
    if (wr_access && hit(paddr, `RCR_OFF_FLAGS) && pstrb[0]) begin
      flag_clr = pwdata[7:0] & `RCR_FLAGS_USED;
    end
  end

  // hardware set wins over a clear in the same cycle
  always_comb begin
    next_reset_cause_flags =
      ((reset_cause_flags & ~flag_clr) | flag_set) &
      `RCR_FLAGS_USED;
  end

  // flags sit on the power-on reset only, so they outlive other resets
  always_ff @(posedge pclk or negedge por_rstn) begin
    if (!por_rstn) begin
      reset_cause_flags <= `RCR_FLAGS_POR;
    end else begin
      reset_cause_flags <= next_reset_cause_flags;
    end
  end

  // latest cause code, kept like the flags
  always_comb begin
    next_last_cause = last_cause;
    if (flag_set != `RCR_FLAGS_ZERO) begin
      next_last_cause = encode(flag_set);
    end
  end

  always_ff @(posedge pclk or negedge por_rstn) begin
    if (!por_rstn) begin
      last_cause <= rcr_pkg::rcr_cause_por;
    end else begin
      last_cause <= next_last_cause;
    end
  end

  // saturating count of recorded resets; any write to it with byte lane 0 enabled clears it
  always_comb begin
    next_event_count = event_count;
    if (wr_access && hit(paddr, `RCR_OFF_COUNT) && pstrb[0]) begin
      next_event_count = `RCR_FLAGS_ZERO;
    end
    if (flag_set != `RCR_FLAGS_ZERO &&
        next_event_count != `RCR_COUNT_MAX) begin
      next_event_count = next_event_count + `RCR_COUNT_ONE;
    end
  end

  always_ff @(posedge pclk or negedge por_rstn) begin
    if (!por_rstn) begin
      event_count <= `RCR_COUNT_ONE;
    end else begin
      event_count <= next_event_count;
    end
  end

  // interrupt mask, plain read/write, cleared by system reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask <= `RCR_MASK_RST;
    end else if (wr_access && hit(paddr, `RCR_OFF_MASK) &&
                 pstrb[0]) begin
      irq_mask <= pwdata[7:0] & `RCR_FLAGS_USED;
    end
  end

  // level interrupt while any unmasked flag stands
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(next_reset_cause_flags & irq_mask);
    end
  end

  // read mux; unused and reserved bits read zero
  always_comb begin
    next_prdata = `RCR_WORD_ZERO;
    if (hit(paddr, `RCR_OFF_FLAGS)) begin
      next_prdata[7:0] = reset_cause_flags;
    end else if (hit(paddr, `RCR_OFF_MASK)) begin
      next_prdata[7:0] = irq_mask;
    end else if (hit(paddr, `RCR_OFF_LAST)) begin
      next_prdata[2:0] = last_cause;
    end else if (hit(paddr, `RCR_OFF_COUNT)) begin
      next_prdata[7:0] = event_count;
    end
  end

  // unmapped address answers with an error
  assign next_err = !mapped(paddr);

  // ready rises in the access cycle, giving one access cycle per transfer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= setup_phase;
    end
  end

  // error flag captured in setup, valid with ready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else if (setup_phase) begin
      pslverr <= next_err;
    end else begin
      pslverr <= 1'b0;
    end
  end

  // read data captured in setup and held through the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= `RCR_WORD_ZERO;
    end else if (rd_setup) begin
      prdata <= next_prdata;
    end else if (!psel) begin
      prdata <= `RCR_WORD_ZERO;
    end
  end

endmodule : rcr_top

/* verification/rcr_checker_properties.sv */
`timescale 1ns/10ps
// bus and interrupt relations seen at the block's ports
module rcr_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // decoded bus phases
  wire setup = psel && !penable;
  wire mapped = paddr inside {12'h004, 12'h010, 12'h014, 12'h018};
  wire rd_ok = pready && !pslverr && !pwrite;
  AST_READY_AFTER_SETUP: assert property (setup |=> pready)
    else $error("no ready in access phase");
  AST_NO_READY_IN_SETUP: assert property (setup |-> !pready)
    else $error("ready during setup");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  AST_ERR_UNMAPPED: assert property (setup && !mapped |=> pslverr)
    else $error("unmapped access without error");
  AST_OK_MAPPED: assert property (setup && mapped |=> !pslverr)
    else $error("mapped access with error");
  AST_ERR_READ_ZERO: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("error read returned data");
  AST_RESERVED_ZERO: assert property (rd_ok && paddr == 12'h004 |->
    prdata[31:8] == 24'h0 && !prdata[6])
    else $error("reserved flag bits not zero");
  AST_MASK_ALL_OFF: assert property (pready && pwrite && paddr == 12'h010
    && pwdata[7:0] == 8'h00 |-> ##2 !irq)
    else $error("irq high with all masked");
  // main scenarios reached
  cover property (pslverr);
  cover property ($rose(irq));
  cover property (rd_ok && paddr == 12'h004 && prdata[7:0] == 8'hBF);
endmodule : rcr_checker

bind rcr_top rcr_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));

/* verification/rcr_testbench.sv */
`timescale 1ns/10ps
module testbench;
  logic pclk, presetn, por_rstn, psel, penable, pwrite, irq, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, lfsr;
  logic [6:0] req;
  logic err;
  int mismatches, checked, cyc, mf;
  rcr_top DUT (.pclk(pclk), .presetn(presetn), .por_rstn(por_rstn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(4'hF), .chip_rst_req(req[0]),
    .pin_rst_req(req[1]), .watchdog_rst_req(req[2]),
    .low_voltage_rst_req(req[3]), .brownout_rst_req(req[4]),
    .core_sys_rst_req(req[5]), .core_only_rst_req(req[6]),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
  // 10 MHz clock
  initial begin
    pclk = 0;
    forever #50 pclk = ~pclk;
  end
  // hang guard
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      mismatches++;
      stop_test();
    end
  end
  function automatic logic [31:0] lfsr_step(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_step
  // source request bits to flag positions, bit 6 unused
  function automatic int fb(input logic [6:0] m);
    return {24'h0, m[6], 1'b0, m[5:0]};
  endfunction : fb
  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // one apb transfer, held until pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    // wait for the answer; only the hang guard ends a stuck wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  task automatic rdchk(input string nm, input logic [11:0] a, input int e);
    apb(0, a, 0);
    chk(nm, e, rd);
  endtask : rdchk
  // raise source requests for three cycles
  task automatic fire(input logic [6:0] m);
    @(posedge pclk);
    req <= m;
    repeat (3) @(posedge pclk);
    req <= 0;
    repeat (4) @(posedge pclk);
  endtask : fire
  task automatic stop_test();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : stop_test
  // main sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata, req} = '0;
    presetn = 0;
    por_rstn = 0;
    lfsr = 32'hDBE5D4F7;
    repeat (12) @(posedge pclk);
    presetn <= 1;
    por_rstn <= 1;
    mf = 1;
    rdchk("flags after por", 12'h004, mf);
    rdchk("last cause after por", 12'h014, 1);
    rdchk("count after por", 12'h018, 1);
    apb(1, 12'h004, 32'h0);
    rdchk("flags kept", 12'h004, mf);
    apb(0, 12'h008, 32'h0);
    chk("unmapped err", 1, err);
    chk("unmapped data", 0, rd);
    $display("test reset done");
    apb(1, 12'h004, 32'h1);
    for (int i = 0; i < 7; i++) begin
      fire(7'h01 << i);
      mf = fb(7'h01 << i);
      rdchk("flag set", 12'h004, mf);
      apb(1, 12'h004, mf);
      rdchk("flag cleared", 12'h004, 0);
    end
    rdchk("last cause cpu", 12'h014, 7);
    rdchk("count of resets", 12'h018, 8);
    apb(1, 12'h018, 32'h0);
    rdchk("count cleared", 12'h018, 0);
    $display("test sources done");
    for (int i = 0; i < 8; i++) begin
      fire(7'h7F);
      lfsr = lfsr_step(lfsr);
      apb(1, 12'h004, lfsr);
      mf = 32'hBF & ~{24'h0, lfsr[7:0]};
      rdchk("flags w1c", 12'h004, mf);
    end
    $display("test random clear done");
    fire(7'h7F);
    mf = 32'hBF;
    @(posedge pclk);
    presetn <= 0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    rdchk("flags through reset", 12'h004, mf);
    $display("test bus reset done");
    apb(1, 12'h010, 32'h04);
    rdchk("mask", 12'h010, 32'h04);
    chk("irq masked in", 1, irq);
    apb(1, 12'h004, 32'h04);
    @(posedge pclk);
    chk("irq after clear", 0, irq);
    fire(7'h04);
    chk("irq on watchdog", 1, irq);
    apb(1, 12'h010, 32'h0);
    // irq still sees the old mask at the write edge
    repeat (2) @(posedge pclk);
    chk("irq masked out", 0, irq);
    $display("test irq done");
    stop_test();
  end
endmodule : testbench
